/* core/scpr_pkg.sv */
package scpr_pkg;

   // ****************************************
   // Widths and stack depth
   // ****************************************
   localparam int BANK_W   = 2;
   localparam int FILE_W   = 4;
   localparam int DIGIT_W  = 4;
   localparam int RPTR_W   = BANK_W + FILE_W + DIGIT_W;
   localparam int PAGE_W   = 7;
   localparam int OFFS_W   = 7;
   localparam int PC_W     = PAGE_W + OFFS_W;
   localparam int STK_N    = 8;
   localparam int STK_IW   = 3;
   localparam int CYC_W    = 2;

   // ****************************************
   // Reset values and counts
   // ****************************************
   localparam logic [PC_W-1:0]   PC_RST    = 14'h0000;
   localparam logic [STK_IW-1:0] SP_RST    = 3'h7;
   localparam logic [CYC_W-1:0]  NULL_CYC  = 2'h1;

   // ****************************************
   // Instruction slot descriptor from decode
   // ****************************************
   typedef enum logic [1:0] {
      SCPR_FLOW_SEQ,
      SCPR_FLOW_JUMP,
      SCPR_FLOW_CALL,
      SCPR_FLOW_RET
   } scpr_flow_t;

   typedef struct packed {
      logic              valid;
      scpr_flow_t        flow;
      logic              load_page;
      logic              load_offs;
      logic [PAGE_W-1:0] page;
      logic [OFFS_W-1:0] offs;
      logic [CYC_W-1:0]  cycles;
      logic              short_on_skip;
      logic              skip_cond;
   } scpr_instr_t;

   typedef struct packed {
      logic [BANK_W-1:0]  bank;
      logic [FILE_W-1:0]  file;
      logic [DIGIT_W-1:0] digit;
   } scpr_ptr_t;

endpackage : scpr_pkg

/* core/scpr_core.sv */
`timescale 1ns/1ps
module scpr_core
   import scpr_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   // Instruction slot from decode
   input  wire scpr_instr_t       instr_i,
   // Pointer register loads
   input  wire logic              ptr_we_i,
   input  wire scpr_ptr_t         ptr_i,
   // Status
   output logic [RPTR_W-1:0]      ram_pointer_o,
   output logic [PAGE_W-1:0]      count_upper_page_o,
   output logic [OFFS_W-1:0]      count_lower_offset_o,
   output logic [STK_IW-1:0]      stack_top_index_o,
   output logic [PC_W-1:0]        return_stack_top_o,
   output logic                   exec_o,
   output logic                   nullify_o,
   output logic                   slot_end_o
);

   // ****************************************
   // Reset synchroniser
   // ****************************************
   logic rst_s1_r;
   logic rst_n_r;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // ****************************************
   // Slot timing and skip
   // ****************************************
   logic [CYC_W-1:0] cyc_r, cyc_nxt;
   logic             skip_r, skip_nxt;
   logic [CYC_W-1:0] len;
   logic             last;

   always_comb
   begin
      len = (instr_i.cycles == '0) ? NULL_CYC : instr_i.cycles;
      if (skip_r && instr_i.short_on_skip)
      begin
         len = NULL_CYC;
      end
      last     = instr_i.valid && (cyc_r + NULL_CYC == len);
      cyc_nxt  = cyc_r;
      skip_nxt = skip_r;
      if (instr_i.valid)
      begin
         cyc_nxt  = last ? '0 : CYC_W'(cyc_r + NULL_CYC);
      end
      // latch at end, clear after one slot
      if (last)
      begin
         skip_nxt = skip_r ? 1'b0 : instr_i.skip_cond;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         cyc_r  <= '0;
         skip_r <= 1'b0;
      end
      else
      begin
         cyc_r  <= cyc_nxt;
         skip_r <= skip_nxt;
      end
   end

   // ****************************************
   // Program counter and return stack
   // ****************************************
   logic [PAGE_W-1:0]        page_r, page_nxt;
   logic [OFFS_W-1:0]        offs_r, offs_nxt;
   logic [STK_IW-1:0]        sp_r, sp_nxt;
   logic [STK_N-1:0][PC_W-1:0] stk_r, stk_nxt;
   logic [RPTR_W-1:0]        rp_r, rp_nxt;
   logic                     eff;
   logic [PC_W-1:0]          pc_inc;

   always_comb
   begin
      eff     = last && !skip_r;
      pc_inc  = PC_W'({page_r, offs_r} + 14'h0001);
      page_nxt = page_r;
      offs_nxt = offs_r;
      sp_nxt   = sp_r;
      stk_nxt  = stk_r;
      rp_nxt   = rp_r;
      if (last)
      begin
         {page_nxt, offs_nxt} = pc_inc;
      end
      if (eff)
      begin
         if (ptr_we_i)
         begin
            rp_nxt = {ptr_i.bank, ptr_i.file, ptr_i.digit};
         end
         unique case (instr_i.flow)
            SCPR_FLOW_CALL:
            begin
               sp_nxt          = STK_IW'(sp_r + 3'h1);
               stk_nxt[sp_nxt] = pc_inc;
            end
            SCPR_FLOW_RET:
            begin
               {page_nxt, offs_nxt} = stk_r[sp_r];
               sp_nxt               = STK_IW'(sp_r - 3'h1);
            end
            SCPR_FLOW_SEQ,
            SCPR_FLOW_JUMP:
            begin
            end
         endcase
         if (instr_i.flow != SCPR_FLOW_RET && instr_i.load_page)
         begin
            page_nxt = instr_i.page;
         end
         if (instr_i.flow != SCPR_FLOW_RET && instr_i.load_offs)
         begin
            offs_nxt = instr_i.offs;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         page_r <= PC_RST[PC_W-1:OFFS_W];
         offs_r <= PC_RST[OFFS_W-1:0];
         sp_r   <= SP_RST;
         stk_r  <= '0;
         rp_r   <= '0;
      end
      else
      begin
         page_r <= page_nxt;
         offs_r <= offs_nxt;
         sp_r   <= sp_nxt;
         stk_r  <= stk_nxt;
         rp_r   <= rp_nxt;
      end
   end

   // ****************************************
   // Registered status outputs
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         ram_pointer_o        <= '0;
         count_upper_page_o   <= PC_RST[PC_W-1:OFFS_W];
         count_lower_offset_o <= PC_RST[OFFS_W-1:0];
         stack_top_index_o    <= SP_RST;
         return_stack_top_o   <= '0;
         exec_o               <= 1'b0;
         nullify_o            <= 1'b0;
         slot_end_o           <= 1'b0;
      end
      else
      begin
         ram_pointer_o        <= rp_nxt;
         count_upper_page_o   <= page_nxt;
         count_lower_offset_o <= offs_nxt;
         stack_top_index_o    <= sp_nxt;
         return_stack_top_o   <= stk_nxt[sp_nxt];
         exec_o               <= eff;
         nullify_o            <= last && skip_r;
         slot_end_o           <= last;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_null_no_exec: assert property (
      @(posedge clk_i) disable iff (!rst_n_r) nullify_o |-> !exec_o)
      else $error("nullified slot executed");
   a_pc_step_one: assert property (
      @(posedge clk_i) disable iff (!rst_n_r) nullify_o |->
      {count_upper_page_o, count_lower_offset_o} ==
      PC_W'({$past(page_r), $past(offs_r)} + 14'h0001))
      else $error("nullified slot did not step by one");
   a_short_skip: assert property (
      @(posedge clk_i) disable iff (!rst_n_r)
      (instr_i.valid && skip_r && instr_i.short_on_skip) |-> last)
      else $error("short nullified slot not one cycle");
   a_len_kept: assert property (
      @(posedge clk_i) disable iff (!rst_n_r)
      (instr_i.valid && !instr_i.short_on_skip && instr_i.cycles == 2'h2 && cyc_r == '0)
      |-> !last)
      else $error("slot length changed");
   a_skip_once: assert property (
      @(posedge clk_i) disable iff (!rst_n_r) nullify_o |-> !skip_r)
      else $error("skip held past one slot");
   a_ptr_cat: assert property (
      @(posedge clk_i) disable iff (!rst_n_r) (eff && ptr_we_i) |=>
      ram_pointer_o == {$past(ptr_i.bank), $past(ptr_i.file), $past(ptr_i.digit)})
      else $error("pointer mismatch");
   a_stack_push: assert property (
      @(posedge clk_i) disable iff (!rst_n_r) (eff && instr_i.flow == SCPR_FLOW_CALL)
      |=> stack_top_index_o == STK_IW'($past(sp_r) + 3'h1))
      else $error("push index wrong");
   a_page_load: assert property (
      @(posedge clk_i) disable iff (!rst_n_r)
      (eff && instr_i.flow == SCPR_FLOW_JUMP && instr_i.load_page && !instr_i.load_offs)
      |=> count_upper_page_o == $past(instr_i.page) &&
      count_lower_offset_o == 7'($past(offs_r) + 7'h01))
      else $error("page load wrong");

endmodule : scpr_core

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench
   import scpr_pkg::*;
;
   // ****************************************
   // Stimulus and observed ports
   // ****************************************
   logic              clk_i    = 1'b0;
   logic              nrst_i   = 1'b0;
   scpr_instr_t       instr_i  = '0;
   logic              ptr_we_i = 1'b0;
   scpr_ptr_t         ptr_i    = '0;
   logic [RPTR_W-1:0] ram_pointer_o;
   logic [PAGE_W-1:0] count_upper_page_o;
   logic [OFFS_W-1:0] count_lower_offset_o;
   logic [STK_IW-1:0] stack_top_index_o;
   logic [PC_W-1:0]   return_stack_top_o;
   logic              exec_o;
   logic              nullify_o;
   logic              slot_end_o;
   int                mismatches  = 0;
   int                comparisons = 0;
   int                sp          = 7;
   logic [15:0]       pc          = '0;
   logic [15:0]       ptr         = '0;
   logic [15:0]       stk [8]     = '{default: '0};
   logic              skip        = 1'b0;

   always #5 clk_i = ~clk_i;

   scpr_core scpr_core_i (
      .clk_i               (clk_i),
      .nrst_i              (nrst_i),
      .instr_i             (instr_i),
      .ptr_we_i            (ptr_we_i),
      .ptr_i               (ptr_i),
      .ram_pointer_o       (ram_pointer_o),
      .count_upper_page_o  (count_upper_page_o),
      .count_lower_offset_o(count_lower_offset_o),
      .stack_top_index_o   (stack_top_index_o),
      .return_stack_top_o  (return_stack_top_o),
      .exec_o              (exec_o),
      .nullify_o           (nullify_o),
      .slot_end_o          (slot_end_o)
   );

   task test_done;
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   function automatic scpr_instr_t mk(input int fl, input int cy, input bit sh, input bit sk,
                                      input logic [6:0] pg, input logic [6:0] of);
      scpr_instr_t i;
      i = '0;
      i.valid = 1'b1;
      i.flow = scpr_flow_t'(fl);
      i.cycles = 2'(cy);
      // Zero page or offset leaves that half unloaded
      i.load_page = (fl == 1 || fl == 2) && pg != 7'h00;
      i.load_offs = (fl == 1 || fl == 2) && of != 7'h00;
      i.page = pg;
      i.offs = of;
      i.short_on_skip = sh;
      i.skip_cond = sk;
      return i;
   endfunction : mk

   // ****************************************
   // One slot, then model update and compare
   // ****************************************
   task slot(input scpr_instr_t ins, input logic we, input scpr_ptr_t p);
      int          n;
      int          k;
      logic        was;
      logic [15:0] nx;
      n = (ins.cycles == 2'h0) ? 1 : int'(ins.cycles);
      if (skip && ins.short_on_skip)
         n = 1;
      @(posedge clk_i);
      instr_i <= ins;
      ptr_we_i <= we;
      ptr_i <= p;
      for (k = 1; k <= n + 3; k++)
      begin
         @(posedge clk_i);
         if (k == n)
            instr_i.valid <= 1'b0;
         #1;
         if (slot_end_o === 1'b1)
            break;
      end
      chk(16'(k), 16'(n));
      if (k > n + 3)
         test_done();
      was = skip;
      nx = (pc + 16'h0001) & 16'h3FFF;
      if (skip)
      begin
         pc = nx;
         skip = 1'b0;
      end
      else
      begin
         if (we)
            ptr = 16'(p);
         pc = nx;
         if (ins.load_page)
            pc[13:7] = ins.page;
         if (ins.load_offs)
            pc[6:0] = ins.offs;
         case (ins.flow)
            SCPR_FLOW_CALL:
            begin
               sp = (sp + 1) & 7;
               stk[sp] = nx;
            end
            SCPR_FLOW_RET:
            begin
               pc = stk[sp];
               sp = (sp - 1) & 7;
            end
            default: ;
         endcase
         skip = ins.skip_cond;
      end
      chk(16'({exec_o, nullify_o}), was ? 16'h0001 : 16'h0002);
      chk(16'(ram_pointer_o), ptr);
      chk(16'({count_upper_page_o, count_lower_offset_o}), pc);
      chk(16'(stack_top_index_o), 16'(sp));
      chk(16'(return_stack_top_o), stk[sp]);
   endtask : slot

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      void'($urandom(32'hA019));
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      chk(16'({stack_top_index_o, ram_pointer_o}), 16'h1C00);
      chk(16'({count_upper_page_o, count_lower_offset_o}), 16'h0000);
      slot(mk(1, 1, 0, 0, 7'h0A, 7'h7F), 1'b1, 10'h3A5);
      slot(mk(0, 2, 0, 1, 7'h00, 7'h00), 1'b0, 10'h000);
      slot(mk(3, 3, 1, 0, 7'h00, 7'h00), 1'b1, 10'h155);
      slot(mk(0, 3, 0, 1, 7'h00, 7'h00), 1'b0, 10'h000);
      slot(mk(0, 3, 0, 1, 7'h00, 7'h00), 1'b0, 10'h000);
      slot(mk(2, 2, 1, 1, 7'h11, 7'h22), 1'b0, 10'h000);
      slot(mk(2, 0, 1, 0, 7'h33, 7'h44), 1'b0, 10'h000);
      slot(mk(0, 1, 0, 0, 7'h00, 7'h00), 1'b0, 10'h000);
      slot(mk(1, 2, 0, 0, 7'h05, 7'h00), 1'b0, 10'h000);
      slot(mk(1, 1, 0, 0, 7'h00, 7'h12), 1'b0, 10'h000);
      repeat (300)
         slot(mk($urandom_range(3, 0), $urandom_range(3, 0), $urandom_range(1, 0),
                 $urandom_range(2, 0) == 0, 7'($urandom), 7'($urandom)),
              1'($urandom), 10'($urandom));
      test_done();
   end
endmodule : testbench
